// ---- hdl/tcps_timer_clock_select.sv ----
// Timer clock divide control register and per-timer count enables
//
// Overview of operation
// - Timer C bit: 0 divide by twelve, 1 full clock
// - Timer C bit ignored in baud or counter mode
// - Timer B bit: 0 divide by twelve, 1 full
// - Timer A bit: 0 divide by twelve, 1 full
//
// One free-running divider serves all three timers. A timer on the full clock
// ticks every cycle, and a divided timer ticks once per divider wrap. The tick
// outputs are registered, so a new selection shows one cycle after it is stored.
// In the two ignored modes of timer C this block offers no tick at all. The pin
// and baud paths that clock timer C then are built elsewhere.
`timescale 1ns/1ns
module tcps_timer_clock_select
    import tcps_pkg::*;
#(
    parameter int DIVIDE = TCPS_DIVIDE
)
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    input wire logic timer_c_count_source_sel,
    input wire logic timer_c_baud_mode,
    output logic timer_a_tick,
    output logic timer_b_tick,
    output logic timer_c_tick
);

    typedef struct packed {
        logic [7:0] ctrl;
        logic [3:0] div;
        logic [7:0] rdata;
        logic a_tick;
        logic b_tick;
        logic c_tick;
    } tcps_state_t;

    tcps_state_t st_q;
    tcps_state_t st_d;
    logic div_pulse;

    // The divider is four bits wide, so ratios above sixteen cannot be served
    localparam logic [3:0] DIV_LAST = 4'(DIVIDE - 1);

    // Refuse a ratio that the four-bit divider cannot count
    if (DIVIDE < 2 || DIVIDE > 16) begin : g_bad_divide
        $error("DIVIDE must lie between 2 and 16");
    end

    // Choose the full clock or the divided pulse for one timer
    function automatic logic tcps_pick(input logic sel, input logic slow);
        tcps_pick = sel ? 1'b1 : slow;
    endfunction

    // Divider wraps after DIV_LAST (eleven by default); the pulse is shared so all slow timers stay in phase
    always_comb begin
        st_d = st_q;
        div_pulse = (st_q.div == DIV_LAST);
        st_d.div = div_pulse ? 4'h0 : st_q.div + 4'h1;
        if (sfr_wr && sfr_addr == TCPS_CTRL_ADDR) begin
            st_d.ctrl = sfr_wdata & TCPS_WRITE_MASK;
        end
        st_d.rdata = (sfr_rd && sfr_addr == TCPS_CTRL_ADDR) ? st_q.ctrl : 8'h00;
        st_d.a_tick = tcps_pick(st_q.ctrl[TCPS_BIT_A], div_pulse);
        st_d.b_tick = tcps_pick(st_q.ctrl[TCPS_BIT_B], div_pulse);
        // Other modes own the clock of timer C, so no tick is offered here
        if (timer_c_count_source_sel || timer_c_baud_mode) begin
            st_d.c_tick = 1'b0;
        end else begin
            st_d.c_tick = tcps_pick(st_q.ctrl[TCPS_BIT_C], div_pulse);
        end
    end

    // State register, synchronous reset
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st_q <= '{ctrl: TCPS_CTRL_RESET, div: 4'h0, rdata: 8'h00,
                       a_tick: 1'b0, b_tick: 1'b0, c_tick: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign sfr_rdata = st_q.rdata;
    assign timer_a_tick = st_q.a_tick;
    assign timer_b_tick = st_q.b_tick;
    assign timer_c_tick = st_q.c_tick;

    // A divided tick is only known to be divided if the bit was low before it too
    sequence s_a_slow;
        !st_q.ctrl[TCPS_BIT_A] && !$past(st_q.ctrl[TCPS_BIT_A]) && timer_a_tick;
    endsequence

    sequence s_b_slow;
        !st_q.ctrl[TCPS_BIT_B] && !$past(st_q.ctrl[TCPS_BIT_B]) && timer_b_tick;
    endsequence

    // Register access steps used by the readback checks
    sequence s_ctrl_write;
        sfr_wr && sfr_addr == TCPS_CTRL_ADDR;
    endsequence

    sequence s_ctrl_read_only;
        sfr_rd && !sfr_wr && sfr_addr == TCPS_CTRL_ADDR;
    endsequence

    sequence s_ctrl_read_hit;
        sfr_rd && sfr_addr == TCPS_CTRL_ADDR;
    endsequence

    // After a divided tick, no second tick may come eight cycles later while the bit stays low
    chk_a_slow_gap: assert property (@(posedge mclk) disable iff (!resetn)
        s_a_slow ##1 !st_q.ctrl[TCPS_BIT_A] [*8] |-> !timer_a_tick)
        else $error("timer A ticked too soon when divided");
    chk_b_slow_gap: assert property (@(posedge mclk) disable iff (!resetn)
        s_b_slow ##1 !st_q.ctrl[TCPS_BIT_B] [*8] |-> !timer_b_tick)
        else $error("timer B ticked too soon when divided");
    chk_a_fast: assert property (@(posedge mclk) disable iff (!resetn)
        st_q.ctrl[TCPS_BIT_A] |=> timer_a_tick || !$past(resetn))
        else $error("timer A not ticking on full clock");
    chk_b_fast: assert property (@(posedge mclk) disable iff (!resetn)
        $past(st_q.ctrl[TCPS_BIT_B]) && $past(resetn) |-> timer_b_tick)
        else $error("timer B not ticking on full clock");
    chk_b_slow_seen: assert property (@(posedge mclk) disable iff (!resetn)
        !st_q.ctrl[TCPS_BIT_B] [*2] |-> ##[0:12] timer_b_tick)
        else $error("timer B divided tick missing");
    chk_a_slow_seen: assert property (@(posedge mclk) disable iff (!resetn)
        !st_q.ctrl[TCPS_BIT_A] [*2] |-> ##[0:12] timer_a_tick)
        else $error("timer A divided tick missing");

    // A divided timer ticks exactly one cycle after each divider pulse, in step with the wrap
    chk_a_slow_tick: assert property (@(posedge mclk) disable iff (!resetn)
        $past(resetn) && !$past(st_q.ctrl[TCPS_BIT_A])
        |-> timer_a_tick == $past(div_pulse))
        else $error("timer A divided tick out of phase");
    chk_b_slow_tick: assert property (@(posedge mclk) disable iff (!resetn)
        $past(resetn) && !$past(st_q.ctrl[TCPS_BIT_B])
        |-> timer_b_tick == $past(div_pulse))
        else $error("timer B divided tick out of phase");
    chk_c_slow_tick: assert property (@(posedge mclk) disable iff (!resetn)
        $past(resetn) && !$past(st_q.ctrl[TCPS_BIT_C])
        && !$past(timer_c_count_source_sel || timer_c_baud_mode)
        |-> timer_c_tick == $past(div_pulse))
        else $error("timer C divided tick out of phase");

    // The divider stays inside its range and steps by one between wraps
    chk_div_range: assert property (@(posedge mclk) disable iff (!resetn)
        st_q.div <= DIV_LAST)
        else $error("divider left its range");
    chk_div_step: assert property (@(posedge mclk) disable iff (!resetn)
        $past(resetn) && !$past(div_pulse)
        |-> st_q.div == $past(st_q.div) + 4'h1)
        else $error("divider skipped a count");
    chk_c_ignored: assert property (@(posedge mclk) disable iff (!resetn)
        $past(timer_c_count_source_sel || timer_c_baud_mode) |-> !timer_c_tick)
        else $error("timer C ticked while bit ignored");
    chk_c_fast: assert property (@(posedge mclk) disable iff (!resetn)
        $past(st_q.ctrl[TCPS_BIT_C] && !timer_c_count_source_sel && !timer_c_baud_mode)
        && $past(resetn) |-> timer_c_tick)
        else $error("timer C not ticking on full clock");
    chk_c_slow_rate: assert property (@(posedge mclk) disable iff (!resetn)
        timer_c_tick && !$past(st_q.ctrl[TCPS_BIT_C]) && !st_q.ctrl[TCPS_BIT_C]
        |=> !timer_c_tick)
        else $error("timer C divided tick back to back");
    chk_reserved_zero: assert property (@(posedge mclk) disable iff (!resetn)
        (sfr_rdata & ~TCPS_WRITE_MASK) == 8'h00)
        else $error("reserved bits read nonzero");
    chk_write_read: assert property (@(posedge mclk) disable iff (!resetn)
        s_ctrl_write ##1 s_ctrl_read_only
        |=> sfr_rdata == ($past(sfr_wdata, 2) & TCPS_WRITE_MASK))
        else $error("register readback mismatch");

    // Read data stands for one cycle per read and is zero otherwise
    chk_idle_read: assert property (@(posedge mclk) disable iff (!resetn)
        !sfr_rd |=> sfr_rdata == 8'h00)
        else $error("read data not zero while idle");
    chk_miss_read: assert property (@(posedge mclk) disable iff (!resetn)
        sfr_rd && sfr_addr != TCPS_CTRL_ADDR |=> sfr_rdata == 8'h00)
        else $error("unmapped address read nonzero");
    chk_read_value: assert property (@(posedge mclk) disable iff (!resetn)
        s_ctrl_read_hit |=> sfr_rdata == $past(st_q.ctrl))
        else $error("read data differs from stored value");

    // The stored value changes only on a write that hits the register
    chk_ctrl_hold: assert property (@(posedge mclk) disable iff (!resetn)
        $past(resetn) && !$past(sfr_wr && sfr_addr == TCPS_CTRL_ADDR)
        |-> $stable(st_q.ctrl))
        else $error("control value changed without a write");
    chk_ctrl_mask: assert property (@(posedge mclk) disable iff (!resetn)
        (st_q.ctrl & ~TCPS_WRITE_MASK) == 8'h00)
        else $error("unused control bits were stored");
endmodule

// ---- shared/tcps_pkg.sv ----
// Package: register map, field positions and divider constants for the timer clock select
package tcps_pkg;
    localparam logic [7:0] TCPS_CTRL_ADDR = 8'h8E;
    localparam logic [7:0] TCPS_CTRL_RESET = 8'h00;
    localparam int TCPS_BIT_C = 5;
    localparam int TCPS_BIT_B = 4;
    localparam int TCPS_BIT_A = 3;
    localparam logic [7:0] TCPS_WRITE_MASK = 8'h38;
    localparam int TCPS_DIVIDE = 12;
    localparam logic [3:0] TCPS_DIV_LAST = 4'hB;
endpackage

// ---- test/tb_top.sv ----
// Testbench for the timer clock divide control register and its tick outputs
`timescale 1ns/1ns
module tb_top;
    import tcps_pkg::*;
    logic mclk = 0, resetn = 0, wr_q = 0, rd_q = 0, src = 0, baud = 0;
    logic [7:0] adr = 8'h00, wd = 8'h00, rdata, v, na, nb, nc;
    logic ta, tb, tc;
    int bad_count = 0, n_compared = 0;
    tcps_timer_clock_select dut(.mclk(mclk), .resetn(resetn), .sfr_addr(adr), .sfr_wdata(wd),
        .sfr_wr(wr_q), .sfr_rd(rd_q), .sfr_rdata(rdata), .timer_c_count_source_sel(src),
        .timer_c_baud_mode(baud), .timer_a_tick(ta), .timer_b_tick(tb), .timer_c_tick(tc));
    initial begin
        forever #4 mclk = ~mclk;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One-cycle strobes, released at the next edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk) {adr, wd, wr_q} <= {a, d, 1'b1};
        @(posedge mclk) wr_q <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk) {adr, rd_q} <= {a, 1'b1};
        @(posedge mclk) rd_q <= 1'b0;
        #1 v = rdata;
    endtask
    // Settle, then count ticks over two full divide periods
    task automatic ticks();
        {na, nb, nc} = '0;
        repeat (3) @(posedge mclk);
        repeat (2 * TCPS_DIVIDE) begin
            @(posedge mclk) #1;
            {na, nb, nc} = {na + ta, nb + tb, nc + tc};
        end
    endtask
    task automatic results();
        if (bad_count == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        rd(TCPS_CTRL_ADDR);
        chk(v, TCPS_CTRL_RESET);
        wr(TCPS_CTRL_ADDR, 8'hF8);
        rd(TCPS_CTRL_ADDR);
        chk(v, 8'h38);
        rd(8'h8D);
        chk(v, 8'h00);
        // Only timer C on full clock: bits must act independently
        wr(TCPS_CTRL_ADDR, 8'h20);
        ticks();
        chk(nc, 8'h18);
        chk(nb, 8'h02);
        chk(na, 8'h02);
        wr(TCPS_CTRL_ADDR, 8'h18);
        ticks();
        chk(na, 8'h18);
        chk(nb, 8'h18);
        chk(nc, 8'h02);
        wr(TCPS_CTRL_ADDR, 8'h20);
        @(posedge mclk) baud <= 1'b1;
        ticks();
        chk(nc, 8'h00);
        chk(na, 8'h02);
        chk(nb, 8'h02);
        @(posedge mclk) {baud, src} <= 2'b01;
        ticks();
        chk(nc, 8'h00);
        // Reset in mid-run must clear the stored selection
        @(posedge mclk) resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        rd(TCPS_CTRL_ADDR);
        chk(v, TCPS_CTRL_RESET);
        results();
    end
    initial begin
        #20000;
        bad_count++;
        results();
    end
endmodule
